// *** ecs_engine.sv ***
// Metering engine end: calibration and per-cycle energy accumulation
`timescale 1ns/1ns
`include "ecs_consts.svh"

// How it works
// - Calibration accumulates voltage times each current
// - Calibration energy sixteen times smaller
// - Meter constants scale only normal results
// - Calibration starts at next rising zero crossing
// - Accumulate programmed periods, then store results
// - Stored calibration results set ready flag
// - Host selects current, loads parameters, then mode
// - Host repeats sequence for second point
// - Measure mode posts energy every mains period
// - Host discards first per-cycle result
// - Zero-cross and sample-ready flags mark results
// - Host clears sample-ready before processing
// - Energy plus offset, times gain over 2^14
// - Offset per product, limited to 2^30
// - Single point: host zeroes low terms
module ecs_engine (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // Link to host
  ecs_link_if.dev                 link,
  // Sample stream
  input  wire logic               sample_valid,
  input  wire logic signed [15:0] voltage_sample,
  input  wire logic signed [15:0] current1_sample,
  input  wire logic signed [15:0] current2_sample,
  // Status
  output ecs_pkg::ecs_mode_t      mode_now,
  output logic                    accumulating
);
  import ecs_pkg::*;

  ecs_dev_s_t q;
  ecs_dev_s_t d;

  // --------------------------------------------------------------------------
  // Arithmetic helpers
  // --------------------------------------------------------------------------
  // Offsets beyond the legal range are limited, not wrapped
  function automatic logic signed [47:0] clamp_off(input logic signed [31:0] off);
    logic signed [31:0] c;
    c = off;
    if (off > `ECS_OFF_LIM) begin
      c = `ECS_OFF_LIM;
    end else if (off < -`ECS_OFF_LIM) begin
      c = -`ECS_OFF_LIM;
    end
    return 48'(c);
  endfunction : clamp_off

  function automatic logic signed [47:0] product(input logic signed [15:0] v,
                                                 input logic signed [15:0] i,
                                                 input logic signed [31:0] off);
    logic signed [31:0] p;
    p = v * i;
    return 48'(p) + clamp_off(off);
  endfunction : product

  function automatic logic signed [47:0] apply_gain(input logic signed [47:0] acc,
                                                    input logic [15:0]        gain);
    logic signed [64:0] m;
    m = 65'(acc) * 65'($signed({1'b0, gain}));
    return 48'(m >>> `ECS_GAIN_SHIFT);
  endfunction : apply_gain

  // Raw calibration energy, no meter constant
  function automatic logic signed [31:0] cal_energy(input logic signed [47:0] acc,
                                                    input logic [15:0]        gain);
    logic signed [47:0] g;
    g = apply_gain(acc, gain);
    return 32'(g >>> `ECS_CAL_SHIFT);
  endfunction : cal_energy

  function automatic logic signed [31:0] meas_energy(input logic signed [47:0] acc,
                                                     input logic [15:0]        gain,
                                                     input logic [15:0]        mc);
    logic signed [64:0] m;
    m = 65'(apply_gain(acc, gain)) * 65'($signed({1'b0, mc}));
    return 32'(m >>> `ECS_MC_SHIFT);
  endfunction : meas_energy

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  logic signed [47:0] p1;
  logic signed [47:0] p2;
  logic               zx;
  logic [15:0]        periods_nx;

  always_comb begin
    d          = q;
    p1         = product(voltage_sample, current1_sample, q.poff1);
    p2         = q.cur2 ? product(voltage_sample, current2_sample, q.poff2) : 48'sh0;
    zx         = sample_valid && q.v_neg && !voltage_sample[15];
    periods_nx = q.periods + 16'h0001;

    // Clears first, so a flag set in the same cycle wins
    if (link.flag_clr[`ECS_CLR_CAL]) begin
      d.cal_rdy = 1'b0;
    end
    if (link.flag_clr[`ECS_CLR_ZX]) begin
      d.zx_fg = 1'b0;
    end
    if (link.flag_clr[`ECS_CLR_WFS]) begin
      d.wfs_fg = 1'b0;
    end

    if (sample_valid) begin
      d.v_neg = voltage_sample[15];
    end

    // The mode write restarts the engine; a sample in the same cycle is dropped
    if (link.cfg_wr) begin
      if (link.cfg_addr == `ECS_A_CUR2) begin
        d.cur2 = link.cfg_data[0];
      end else if (link.cfg_addr == `ECS_A_GAIN1) begin
        d.gain1 = link.cfg_data[15:0];
      end else if (link.cfg_addr == `ECS_A_GAIN2) begin
        d.gain2 = link.cfg_data[15:0];
      end else if (link.cfg_addr == `ECS_A_POFF1) begin
        d.poff1 = link.cfg_data;
      end else if (link.cfg_addr == `ECS_A_POFF2) begin
        d.poff2 = link.cfg_data;
      end else if (link.cfg_addr == `ECS_A_CALCNT) begin
        d.cal_count = link.cfg_data[15:0];
      end else if (link.cfg_addr == `ECS_A_MC1) begin
        d.mc1 = link.cfg_data[15:0];
      end else if (link.cfg_addr == `ECS_A_MC2) begin
        d.mc2 = link.cfg_data[15:0];
      end else if (link.cfg_addr == `ECS_A_MODE) begin
        d.mode    = ecs_mode_t'(link.cfg_data[1:0]);
        d.acc1    = 48'sh0;
        d.acc2    = 48'sh0;
        d.periods = 16'h0000;
        if (link.cfg_data[1:0] == ECS_CAL) begin
          d.st      = ECS_WAIT_ZX;
          d.cal_rdy = 1'b0;
        end else if (link.cfg_data[1:0] == ECS_MEASURE) begin
          d.st = ECS_RUN;
        end else begin
          d.st = ECS_HOLD;
        end
      end
    end else if (sample_valid) begin
      case (q.st)
        ECS_WAIT_ZX: begin
          if (zx) begin
            d.acc1    = p1;
            d.acc2    = p2;
            d.periods = 16'h0000;
            d.st      = ECS_ACCUM;
          end
        end
        ECS_ACCUM: begin
          // Energy runs on across crossings; only the last one stores it
          d.acc1 = q.acc1 + p1;
          d.acc2 = q.acc2 + p2;
          if (zx) begin
            d.periods = periods_nx;
            if (periods_nx >= q.cal_count) begin
              d.act1    = cal_energy(q.acc1, q.gain1);
              d.act2    = cal_energy(q.acc2, q.gain2);
              d.cal_rdy = 1'b1;
              d.st      = ECS_HOLD;
            end
          end
        end
        ECS_RUN: begin
          if (zx) begin
            d.per1   = meas_energy(q.acc1, q.gain1, q.mc1);
            d.act1   = q.act1 + d.per1;
            if (q.cur2) begin
              d.per2 = meas_energy(q.acc2, q.gain2, q.mc2);
              d.act2 = q.act2 + d.per2;
            end
            d.zx_fg  = 1'b1;
            d.wfs_fg = 1'b1;
            d.acc1   = p1;
            d.acc2   = p2;
          end else begin
            d.acc1 = q.acc1 + p1;
            d.acc2 = q.acc2 + p2;
          end
        end
        default: begin
          d.st = ECS_HOLD;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q           <= '0;
      q.gain1     <= `ECS_GAIN_RST;
      q.gain2     <= `ECS_GAIN_RST;
      q.mc1       <= `ECS_MC_RST;
      q.mc2       <= `ECS_MC_RST;
      q.cal_count <= `ECS_CALCNT_RST;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Results hold once stored; only a later calibration or a measure-mode crossing changes them
  assign link.active_energy_ch1    = q.act1;
  assign link.active_energy_ch2    = q.act2;
  assign link.energy_per_cycle_ch1 = q.per1;
  assign link.energy_per_cycle_ch2 = q.per2;
  assign link.cal_ready_flag       = q.cal_rdy;
  assign link.zero_cross_flag      = q.zx_fg;
  assign link.sample_ready_flag    = q.wfs_fg;
  assign mode_now                  = q.mode;
  assign accumulating              = (q.st == ECS_ACCUM) || (q.st == ECS_RUN);

endmodule : ecs_engine

// *** ecs_consts.svh ***
// Constants of the energy calibration sequencer
`ifndef ECS_CONSTS_SVH
`define ECS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Configuration addresses, written by the host in this order
// ----------------------------------------------------------------------------
`define ECS_A_CUR2     4'h0
`define ECS_A_GAIN1    4'h1
`define ECS_A_GAIN2    4'h2
`define ECS_A_POFF1    4'h3
`define ECS_A_POFF2    4'h4
`define ECS_A_CALCNT   4'h5
`define ECS_A_MC1      4'h6
`define ECS_A_MC2      4'h7
`define ECS_A_MODE     4'h8

// ----------------------------------------------------------------------------
// Flag clear bit positions
// ----------------------------------------------------------------------------
`define ECS_CLR_CAL    0
`define ECS_CLR_ZX     1
`define ECS_CLR_WFS    2

// ----------------------------------------------------------------------------
// Scaling
// ----------------------------------------------------------------------------
`define ECS_GAIN_SHIFT 14
`define ECS_CAL_SHIFT  4
`define ECS_MC_SHIFT   12
`define ECS_OFF_LIM    32'sh40000000

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ECS_GAIN_RST   16'h4000
`define ECS_MC_RST     16'h1000
`define ECS_CALCNT_RST 16'h0001

`endif

// *** ecs_pkg.sv ***
// Types shared by both ends of the energy calibration sequencer
package ecs_pkg;

  // --------------------------------------------------------------------------
  // Modes and states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {ECS_IDLE, ECS_MEASURE, ECS_CAL} ecs_mode_t;
  typedef enum logic [1:0] {ECS_HOLD, ECS_WAIT_ZX, ECS_ACCUM, ECS_RUN} ecs_dev_st_t;
  typedef enum logic [1:0] {ECS_H_IDLE, ECS_H_CFG, ECS_H_WAIT, ECS_H_CLR} ecs_host_st_t;

  // --------------------------------------------------------------------------
  // Device state
  // --------------------------------------------------------------------------
  typedef struct packed {
    ecs_mode_t          mode;
    ecs_dev_st_t        st;
    logic               cur2;
    logic [15:0]        gain1;
    logic [15:0]        gain2;
    logic signed [31:0] poff1;
    logic signed [31:0] poff2;
    logic [15:0]        cal_count;
    logic [15:0]        periods;
    logic [15:0]        mc1;
    logic [15:0]        mc2;
    logic               v_neg;
    logic signed [47:0] acc1;
    logic signed [47:0] acc2;
    logic signed [31:0] act1;
    logic signed [31:0] act2;
    logic signed [31:0] per1;
    logic signed [31:0] per2;
    logic               cal_rdy;
    logic               zx_fg;
    logic               wfs_fg;
  } ecs_dev_s_t;

  // --------------------------------------------------------------------------
  // Host state
  // --------------------------------------------------------------------------
  typedef struct packed {
    ecs_host_st_t       st;
    ecs_mode_t          mode;
    logic               cur2;
    logic [15:0]        gain;
    logic signed [31:0] poff;
    logic [15:0]        cal_count;
    logic [3:0]         idx;
    logic               cfg_wr;
    logic [3:0]         cfg_addr;
    logic [31:0]        cfg_data;
    logic [2:0]         flag_clr;
    logic               first;
    logic               pend;
    logic               res_valid;
    logic signed [31:0] res1;
    logic signed [31:0] res2;
  } ecs_host_s_t;

endpackage : ecs_pkg

// *** ecs_link_if.sv ***
// Link between the metering engine and its host controller
`timescale 1ns/1ns
interface ecs_link_if;
  logic               cfg_wr;
  logic [3:0]         cfg_addr;
  logic [31:0]        cfg_data;
  logic [2:0]         flag_clr;
  logic signed [31:0] active_energy_ch1;
  logic signed [31:0] active_energy_ch2;
  logic signed [31:0] energy_per_cycle_ch1;
  logic signed [31:0] energy_per_cycle_ch2;
  logic               cal_ready_flag;
  logic               zero_cross_flag;
  logic               sample_ready_flag;

  modport dev (
    input  cfg_wr, cfg_addr, cfg_data, flag_clr,
    output active_energy_ch1, active_energy_ch2,
    output energy_per_cycle_ch1, energy_per_cycle_ch2,
    output cal_ready_flag, zero_cross_flag, sample_ready_flag
  );

  modport hst (
    output cfg_wr, cfg_addr, cfg_data, flag_clr,
    input  active_energy_ch1, active_energy_ch2,
    input  energy_per_cycle_ch1, energy_per_cycle_ch2,
    input  cal_ready_flag, zero_cross_flag, sample_ready_flag
  );
endinterface : ecs_link_if

// *** ecs_host.sv ***
// Host controller end: sequences configuration and collects results
`timescale 1ns/1ns
`include "ecs_consts.svh"
module ecs_host (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // Link to engine
  ecs_link_if.hst                  link,
  // User command
  input  wire logic                start,
  input  wire logic                stop,
  input  wire ecs_pkg::ecs_mode_t  mode_req,
  input  wire logic                cur2_req,
  input  wire logic                single_point,
  input  wire logic [15:0]         gain_req,
  input  wire logic signed [31:0]  offset_req,
  input  wire logic [15:0]         cal_count_req,
  // User results
  output logic                     busy,
  output logic                     result_valid,
  output logic signed [31:0]       result_ch1,
  output logic signed [31:0]       result_ch2
);
  import ecs_pkg::*;

  ecs_host_s_t q;
  ecs_host_s_t d;

  // --------------------------------------------------------------------------
  // Data for each configuration address
  // --------------------------------------------------------------------------
  function automatic logic [31:0] cfg_word(input ecs_host_s_t s, input logic [3:0] a);
    logic [31:0] w;
    w = 32'h00000000;
    if (a == `ECS_A_CUR2) begin
      w = {31'h00000000, s.cur2};
    end else if (a == `ECS_A_GAIN1 || a == `ECS_A_GAIN2) begin
      w = {16'h0000, s.gain};
    end else if (a == `ECS_A_POFF1 || a == `ECS_A_POFF2) begin
      w = s.poff;
    end else if (a == `ECS_A_CALCNT) begin
      w = {16'h0000, s.cal_count};
    end else if (a == `ECS_A_MC1 || a == `ECS_A_MC2) begin
      w = {16'h0000, `ECS_MC_RST};
    end else if (a == `ECS_A_MODE) begin
      w = {30'h00000000, s.mode};
    end
    return w;
  endfunction : cfg_word

  always_comb begin
    d           = q;
    d.cfg_wr    = 1'b0;
    d.flag_clr  = 3'h0;
    d.res_valid = 1'b0;
    case (q.st)
      ECS_H_IDLE: begin
        if (start) begin
          d.mode      = mode_req;
          d.cur2      = cur2_req;
          d.gain      = gain_req;
          d.poff      = single_point ? 32'sh00000000 : offset_req;
          d.cal_count = cal_count_req;
          d.idx       = `ECS_A_CUR2;
          d.first     = 1'b1;
          d.st        = ECS_H_CFG;
        end
      end
      ECS_H_CFG: begin
        // Second current first, then parameters, mode last
        d.cfg_wr   = 1'b1;
        d.cfg_addr = q.idx;
        d.cfg_data = cfg_word(q, q.idx);
        d.idx      = q.idx + 4'h1;
        if (q.idx == `ECS_A_MODE) begin
          d.st = (q.mode == ECS_IDLE) ? ECS_H_IDLE : ECS_H_WAIT;
        end
      end
      ECS_H_WAIT: begin
        if (stop) begin
          d.mode = ECS_IDLE;
          d.idx  = `ECS_A_MODE;
          d.st   = ECS_H_CFG;
        end else if (q.mode == ECS_CAL && link.cal_ready_flag) begin
          d.res1      = link.active_energy_ch1;
          d.res2      = link.active_energy_ch2;
          d.res_valid = 1'b1;
          d.flag_clr[`ECS_CLR_CAL] = 1'b1;
          d.st        = ECS_H_IDLE;
        end else if (q.mode == ECS_MEASURE && link.sample_ready_flag) begin
          // Clear before the values are used
          d.flag_clr[`ECS_CLR_WFS] = 1'b1;
          d.flag_clr[`ECS_CLR_ZX]  = 1'b1;
          d.res1  = link.energy_per_cycle_ch1;
          d.res2  = link.energy_per_cycle_ch2;
          d.pend  = ~q.first;
          d.first = 1'b0;
          d.st    = ECS_H_CLR;
        end
      end
      ECS_H_CLR: begin
        d.res_valid = q.pend;
        d.pend      = 1'b0;
        d.st        = ECS_H_WAIT;
      end
      default: begin
        d.st = ECS_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.cfg_wr   = q.cfg_wr;
  assign link.cfg_addr = q.cfg_addr;
  assign link.cfg_data = q.cfg_data;
  assign link.flag_clr = q.flag_clr;
  assign busy          = (q.st != ECS_H_IDLE);
  assign result_valid  = q.res_valid;
  assign result_ch1    = q.res1;
  assign result_ch2    = q.res2;

endmodule : ecs_host

// *** ecs_sva.sv ***
// Concurrent checks on the link between engine and host
`timescale 1ns/1ns
`include "ecs_consts.svh"
module ecs_sva (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rstn,
  // Host to engine
  input wire logic               cfg_wr,
  input wire logic [3:0]         cfg_addr,
  input wire logic [31:0]        cfg_data,
  input wire logic [2:0]         flag_clr,
  // Engine to host
  input wire logic signed [31:0] active_energy_ch1,
  input wire logic signed [31:0] active_energy_ch2,
  input wire logic signed [31:0] energy_per_cycle_ch1,
  input wire logic signed [31:0] energy_per_cycle_ch2,
  input wire logic               cal_ready_flag,
  input wire logic               zero_cross_flag,
  input wire logic               sample_ready_flag
);
  import ecs_pkg::*;
  // ---------------------------------------------------------------------------
  // Hold window: from calibration ready until the next link write
  // ---------------------------------------------------------------------------
  logic hold_q;
  logic hold_d;
  logic rdy_q;
  always_comb hold_d = cfg_wr ? 1'h0 : ((cal_ready_flag && !rdy_q) ? 1'h1 : hold_q);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hold_q <= 1'h0;
      rdy_q  <= 1'h0;
    end else begin
      hold_q <= hold_d;
      rdy_q  <= cal_ready_flag;
    end
  end
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_cfg_seq;
    cfg_wr && cfg_addr < `ECS_A_MODE |=> cfg_wr && cfg_addr == $past(cfg_addr) + 4'h1;
  endproperty
  a_cfg_seq: assert property (p_cfg_seq) else $error("config writes out of order");
  property p_cfg_span;
    cfg_wr && cfg_addr == `ECS_A_CUR2 |-> ##8 cfg_wr && cfg_addr == `ECS_A_MODE;
  endproperty
  a_cfg_span: assert property (p_cfg_span) else $error("mode not written last");
  property p_mode_once;
    cfg_wr && cfg_addr == `ECS_A_MODE |=> !cfg_wr;
  endproperty
  a_mode_once: assert property (p_mode_once) else $error("write after mode select");
  property p_cal_clear;
    cfg_wr && cfg_addr == `ECS_A_MODE && cfg_data[1:0] == ECS_CAL |=> !cal_ready_flag;
  endproperty
  a_cal_clear: assert property (p_cal_clear) else $error("ready kept over new run");
  property p_flags_pair;
    $rose(sample_ready_flag) |-> $rose(zero_cross_flag);
  endproperty
  a_flags_pair: assert property (p_flags_pair) else $error("flags not raised together");
  property p_per_flag;
    !$stable(energy_per_cycle_ch1) |-> sample_ready_flag && zero_cross_flag;
  endproperty
  a_per_flag: assert property (p_per_flag) else $error("result without flags");
  property p_sum;
    $rose(sample_ready_flag) |-> active_energy_ch1 == $past(active_energy_ch1) + energy_per_cycle_ch1;
  endproperty
  a_sum: assert property (p_sum) else $error("running energy not summed");
  property p_act_cause;
    !$stable(active_energy_ch1) && !$past(cfg_wr) |->
      $rose(cal_ready_flag) || $rose(sample_ready_flag);
  endproperty
  a_act_cause: assert property (p_act_cause) else $error("energy moved without event");
  property p_hold;
    hold_q && !cfg_wr |=> $stable(active_energy_ch1) && $stable(active_energy_ch2);
  endproperty
  a_hold: assert property (p_hold) else $error("stored result changed");
  property p_clr_resp;
    $rose(sample_ready_flag) |-> ##[1:4] flag_clr[`ECS_CLR_WFS];
  endproperty
  a_clr_resp: assert property (p_clr_resp) else $error("sample flag not cleared");
endmodule : ecs_sva

// *** tb_top.sv ***
// Self-checking bench for the energy calibration sequencer
`timescale 1ns/1ns
`include "ecs_consts.svh"
module tb_top;
  import ecs_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  localparam int      VAMP = 100;
  localparam int      WD   = 20000;
  logic               clk_sys, rstn, start, stop, cur2_req, single_point;
  logic               sample_valid, busy, result_valid, accumulating;
  ecs_mode_t          mode_req, mode_now;
  logic [15:0]        gain_req, cal_count_req;
  logic signed [31:0] offset_req, result_ch1, result_ch2, e1, e2;
  logic signed [15:0] voltage_sample, current1_sample, current2_sample;
  logic [31:0]        seed = 32'h0001_488F;
  logic signed [31:0] exp1_q[$];
  logic signed [31:0] exp2_q[$];
  int                 errors, total_checks;
  // ---------------------------------------------------------------------------
  // Both ends joined by the link
  // ---------------------------------------------------------------------------
  ecs_link_if u_ecs_link_if ();
  ecs_engine u_ecs_engine (.clk_sys(clk_sys), .rstn(rstn), .link(u_ecs_link_if.dev),
    .sample_valid(sample_valid), .voltage_sample(voltage_sample),
    .current1_sample(current1_sample), .current2_sample(current2_sample),
    .mode_now(mode_now), .accumulating(accumulating));
  ecs_host u_ecs_host (.clk_sys(clk_sys), .rstn(rstn), .link(u_ecs_link_if.hst),
    .start(start), .stop(stop), .mode_req(mode_req), .cur2_req(cur2_req),
    .single_point(single_point), .gain_req(gain_req), .offset_req(offset_req),
    .cal_count_req(cal_count_req), .busy(busy), .result_valid(result_valid),
    .result_ch1(result_ch1), .result_ch2(result_ch2));
  ecs_sva u_ecs_sva (.clk_sys(clk_sys), .rstn(rstn), .cfg_wr(u_ecs_link_if.cfg_wr),
    .cfg_addr(u_ecs_link_if.cfg_addr), .cfg_data(u_ecs_link_if.cfg_data),
    .flag_clr(u_ecs_link_if.flag_clr),
    .active_energy_ch1(u_ecs_link_if.active_energy_ch1),
    .active_energy_ch2(u_ecs_link_if.active_energy_ch2),
    .energy_per_cycle_ch1(u_ecs_link_if.energy_per_cycle_ch1),
    .energy_per_cycle_ch2(u_ecs_link_if.energy_per_cycle_ch2),
    .cal_ready_flag(u_ecs_link_if.cal_ready_flag),
    .zero_cross_flag(u_ecs_link_if.zero_cross_flag),
    .sample_ready_flag(u_ecs_link_if.sample_ready_flag));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic int rnd_amp();
    return int'(xs() & 32'h0000_03FF) + 1;
  endfunction : rnd_amp
  // Gain over 2^14, then the extra calibration shrink
  function automatic logic signed [31:0] scale(input longint acc, input logic [15:0] g,
                                               input int sh);
    return 32'((acc * longint'(g)) >>> `ECS_GAIN_SHIFT >>> sh);
  endfunction : scale
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic chk(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'h1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic send(input int v, input int a, input int b);
    sample_valid    <= 1'h1;
    voltage_sample  <= 16'(v);
    current1_sample <= 16'(a);
    current2_sample <= 16'(b);
    tick(1);
    sample_valid <= 1'h0;
    tick(1);
  endtask : send
  // Crossing samples carry zero voltage, so their product is the offset alone
  task automatic cycles(input int n, input int a, input int b, input logic acc0);
    send(-VAMP, -a, -b);
    chk(accumulating === acc0, "accumulation state before crossing");
    repeat (n) begin
      for (int k = 0; k < 8; k++) begin
        send((k == 0) ? 0 : ((k < 4) ? VAMP : -VAMP), (k < 4) ? a : -a, (k < 4) ? b : -b);
      end
    end
    send(0, a, b);
  endtask : cycles
  task automatic run(input ecs_mode_t m, input logic c2, input logic sp,
                     input logic [15:0] g, input int o, input logic [15:0] n);
    mode_req      <= m;
    cur2_req      <= c2;
    single_point  <= sp;
    gain_req      <= g;
    offset_req    <= o;
    cal_count_req <= n;
    start         <= 1'h1;
    tick(1);
    start <= 1'h0;
    tick(12);
    chk(mode_now === m, "mode not taken");
  endtask : run
  task automatic wait_idle();
    int i;
    i = 0;
    while (busy !== 1'h0 && i < 100) begin
      tick(1);
      i++;
    end
    chk(busy === 1'h0, "host still busy");
  endtask : wait_idle
  task automatic cal_test(input int n, input logic c2);
    int          a, b;
    logic [15:0] g;
    a = rnd_amp();
    b = rnd_amp();
    g = 16'h3000 + 16'(xs() & 32'h0000_0FFF);
    exp1_q.push_back(scale(longint'(n * 7 * VAMP * a), g, `ECS_CAL_SHIFT));
    exp2_q.push_back(c2 ? scale(longint'(n * 7 * VAMP * b), g, `ECS_CAL_SHIFT) : 32'sh0);
    run(ECS_CAL, c2, 1'h1, g, int'(xs()), 16'(n));
    cycles(n, a, b, 1'h0);
    tick(4);
    wait_idle();
    $display("test calibration over %0d periods done", n);
  endtask : cal_test
  task automatic meas_test(input int o, input logic sp, input logic [15:0] g, input int p);
    int     a, b;
    longint oc, lim;
    a = rnd_amp();
    b = rnd_amp();
    lim = `ECS_OFF_LIM;
    oc = sp ? 0 : ((o > lim) ? lim : ((o < -lim) ? -lim : o));
    repeat (p) begin
      exp1_q.push_back(scale(longint'(7 * VAMP * a) + 8 * oc, g, 0));
      exp2_q.push_back(scale(longint'(7 * VAMP * b) + 8 * oc, g, 0));
    end
    run(ECS_MEASURE, 1'h1, sp, g, o, 16'h0001);
    cycles(p, a, b, 1'h1);
    tick(6);
    stop <= 1'h1;
    tick(1);
    stop <= 1'h0;
    wait_idle();
    $display("test measure with offset %0d done", o);
  endtask : meas_test
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // ---------------------------------------------------------------------------
  // Result monitor: oldest note against each delivered result
  // ---------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rstn === 1'h1 && result_valid === 1'h1) begin
      if (exp1_q.size() == 0) begin
        chk(1'h0, "result not expected");
      end else begin
        e1 = exp1_q.pop_front();
        e2 = exp2_q.pop_front();
        chk(result_ch1 === e1, "channel one energy");
        chk(result_ch2 === e2, "channel two energy");
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    int o;
    rstn = 1'h0;
    {start, stop, cur2_req, single_point, sample_valid} = '0;
    mode_req = ECS_IDLE;
    {gain_req, cal_count_req, offset_req} = '0;
    {voltage_sample, current1_sample, current2_sample} = '0;
    tick(10);
    rstn <= 1'h1;
    tick(2);
    chk(busy === 1'h0 && result_valid === 1'h0, "host not idle after reset");
    chk(u_ecs_link_if.cal_ready_flag === 1'h0, "ready flag after reset");
    cal_test(2, 1'h1);
    cal_test(3, 1'h0);
    // Small offset, both clamp limits, then single point dropping the offset
    for (int k = 0; k < 4; k++) begin
      o = (k == 0) ? (int'(xs() & 32'h0000_FFFF) - 32768) : 32'sh7FFF_FFFF;
      o = (k == 2) ? -o : o;
      meas_test(o, k == 3, (k == 1 || k == 2) ? 16'h2000 : 16'h3000 + 16'(xs() & 32'h0FFF), 3);
    end
    chk(exp1_q.size() == 0, "results missing");
    complete_run();
  end
  initial begin
    #(40 * WD);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : tb_top
